// ===== smo_pkg.sv
package smo_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned NS_PER_MS       = 1_000_000;
	localparam int unsigned STEP_MS         = 10;
	localparam int unsigned TICK_CYCLES_DEF = (STEP_MS * NS_PER_MS) / CLK_PERIOD_NS;
	localparam int unsigned HALF_SEC_MS     = 500;
	localparam int unsigned STEPS_PER_HALF  = HALF_SEC_MS / STEP_MS;
	// ****************************************
	// widths and setpoint defaults
	// ****************************************
	localparam int          N_CH     = 2;
	localparam int          DISC_W   = 6;
	localparam int          LONG_W   = 8;
	localparam int          SYNC_W   = 9;
	localparam int          SUB_W    = 6;
	localparam int unsigned DISC_DEF_MS     = 30;
	localparam int unsigned LONG_DEF_MS     = 60_000;
	localparam int unsigned SYNC_DEF_MS     = 3_000;
	localparam logic [DISC_W-1:0] DISC_DEF  = DISC_W'(DISC_DEF_MS / STEP_MS);
	localparam logic [LONG_W-1:0] LONG_DEF  = LONG_W'(LONG_DEF_MS / HALF_SEC_MS);
	localparam logic [SYNC_W-1:0] SYNC_DEF  = SYNC_W'(SYNC_DEF_MS / STEP_MS);
	localparam logic [SUB_W-1:0]  SUB_LAST  = SUB_W'(STEPS_PER_HALF - 1);
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		SMO_POSITION,
		SMO_PARALLEL,
		SMO_FORWARD,
		SMO_BIDIR
	} smo_mode_t;
	typedef enum logic {
		SMO_LC_EQUIV,
		SMO_LC_COMPL
	} smo_curtain_t;
	typedef enum logic [1:0] {
		SMO_OV_UNUSED,
		SMO_OV_SINGLE,
		SMO_OV_EQUIV,
		SMO_OV_COMPL
	} smo_ovr_t;
	typedef enum logic [1:0] {
		SMO_IDLE,
		SMO_MUTE,
		SMO_OVR
	} smo_state_t;
endpackage

// ===== smo_muting.sv
`timescale 1ns/10ps
`default_nettype none
module smo_muting #(
	parameter int unsigned TICK_CYCLES = smo_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        arst_n,
	// configuration
	input  wire smo_pkg::smo_curtain_t       cfgCurtainType,
	input  wire smo_pkg::smo_ovr_t           cfgOverrideType,
	input  wire smo_pkg::smo_mode_t          cfgMutingMode,
	input  wire logic [smo_pkg::DISC_W-1:0]  cfgCurtainDiscTime,
	input  wire logic [smo_pkg::DISC_W-1:0]  cfgOverrideDiscTime,
	input  wire logic [smo_pkg::LONG_W-1:0]  cfgMaxOverrideTime,
	input  wire logic [smo_pkg::LONG_W-1:0]  cfgMaxMutingTime,
	input  wire logic [smo_pkg::SYNC_W-1:0]  cfgSyncTime,
	input  wire logic                        runMode,
	// field inputs
	input  wire logic                        curtainCh1,
	input  wire logic                        curtainCh2,
	input  wire logic                        overrideCh1,
	input  wire logic                        overrideCh2,
	input  wire logic                        muteSensor11,
	input  wire logic                        muteSensor12,
	input  wire logic                        muteSensor21,
	input  wire logic                        muteSensor22,
	// outputs
	output var  logic                        outputEnable,
	output var  logic                        mutingStatus,
	output var  logic                        overrideStatus,
	output var  logic                        faultPresent,
	output var  logic                        syncError,
	output var  logic                        sequenceError,
	output var  logic                        curtainDiscError,
	output var  logic                        overrideDiscError
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// ****************************************
	// 10 ms time base
	// ****************************************
	logic [TICK_W-1:0] tickCnt;
	logic              tick;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt <= '0;
			tick    <= 1'b0;
		end else if (tickCnt == TICK_LAST) begin
			tickCnt <= '0;
			tick    <= 1'b1; // all setpoints count this step
		end else begin
			tickCnt <= tickCnt + 1'b1;
			tick    <= 1'b0;
		end
	end

	// ****************************************
	// input decoding
	// ****************************************
	logic curtainAct;
	logic curtainIdle;
	logic ovrAct;
	logic mismatch [smo_pkg::N_CH];
	logic [smo_pkg::DISC_W-1:0] discTime [smo_pkg::N_CH];
	logic discOver [smo_pkg::N_CH];

	assign discTime[0] = cfgCurtainDiscTime;
	assign discTime[1] = cfgOverrideDiscTime;

	always_comb begin
		unique case (cfgCurtainType)
			smo_pkg::SMO_LC_EQUIV: begin
				curtainAct  = curtainCh1 & curtainCh2;
				curtainIdle = !curtainCh1 & !curtainCh2;
			end
			smo_pkg::SMO_LC_COMPL: begin
				curtainAct  = curtainCh1 & !curtainCh2;
				curtainIdle = !curtainCh1 & curtainCh2;
			end
		endcase
		mismatch[0] = !curtainAct & !curtainIdle;
		unique case (cfgOverrideType)
			smo_pkg::SMO_OV_UNUSED: begin
				ovrAct      = 1'b0;
				mismatch[1] = 1'b0;
			end
			smo_pkg::SMO_OV_SINGLE: begin
				ovrAct      = overrideCh1;
				mismatch[1] = 1'b0;
			end
			smo_pkg::SMO_OV_EQUIV: begin
				ovrAct      = overrideCh1 & overrideCh2;
				mismatch[1] = overrideCh1 ^ overrideCh2;
			end
			smo_pkg::SMO_OV_COMPL: begin
				ovrAct      = overrideCh1 & !overrideCh2;
				mismatch[1] = overrideCh1 ~^ overrideCh2;
			end
		endcase
	end

	// ****************************************
	// discrepancy timers
	// ****************************************
	for (genvar i = 0; i < smo_pkg::N_CH; i++) begin : g_disc
		logic [smo_pkg::DISC_W-1:0] cnt;
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				cnt <= '0;
			end else if (!mismatch[i]) begin
				cnt <= '0;
			end else if (tick && cnt != '1) begin
				cnt <= cnt + 1'b1;
			end
		end
		// zero setpoint disables the
		assign discOver[i] = mismatch[i] && (discTime[i] != '0) &&
			(cnt >= discTime[i]);
	end

	logic curtainOn;
	logic overrideOn;
	assign curtainOn  = curtainAct & !curtainDiscError;
	assign overrideOn = ovrAct & !overrideDiscError;

	// ****************************************
	// sensor pairs and history
	// ****************************************
	logic pairA [smo_pkg::N_CH];
	logic pairB [smo_pkg::N_CH];
	logic syncOver [smo_pkg::N_CH];
	logic prev11;
	logic prev12;
	logic prev21;
	logic prev22;
	logic prevCurtain;
	logic prevRun;

	assign pairA[0] = muteSensor11;
	assign pairB[0] = muteSensor12;
	assign pairA[1] = muteSensor21;
	assign pairB[1] = muteSensor22;

	for (genvar p = 0; p < smo_pkg::N_CH; p++) begin : g_sync
		logic [smo_pkg::SYNC_W-1:0] cnt;
		logic                       used;
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				cnt <= '0;
			end else if (pairA[p] == pairB[p]) begin
				cnt <= '0;
			end else if (tick && cnt != '1) begin
				cnt <= cnt + 1'b1;
			end
		end
		// second pair is sync-checked only in both-direction mode
		assign used = (p == 0) ? (cfgMutingMode != smo_pkg::SMO_POSITION) :
			(cfgMutingMode == smo_pkg::SMO_BIDIR);
		assign syncOver[p] = used && (pairA[p] != pairB[p]) &&
			(cnt >= cfgSyncTime);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev11      <= 1'b0;
			prev12      <= 1'b0;
			prev21      <= 1'b0;
			prev22      <= 1'b0;
			prevCurtain <= 1'b0;
			prevRun     <= 1'b0;
		end else begin
			prev11      <= muteSensor11;
			prev12      <= muteSensor12;
			prev21      <= muteSensor21;
			prev22      <= muteSensor22;
			prevCurtain <= curtainOn;
			prevRun     <= runMode;
		end
	end

	logic anyOn;
	logic allOff;
	logic rise12;
	logic rise21;
	logic rise22;
	logic curtainFall;
	logic runEntry;
	assign anyOn  = muteSensor11 | muteSensor12 | muteSensor21 | muteSensor22;
	assign allOff = !anyOn;
	assign rise12 = muteSensor12 & !prev12;
	assign rise21 = muteSensor21 & !prev21;
	assign rise22 = muteSensor22 & !prev22;
	assign curtainFall = prevCurtain & !curtainOn;
	assign runEntry    = runMode & !prevRun;

	// ****************************************
	// sequence tracking
	// ****************************************
	smo_pkg::smo_state_t state;
	smo_pkg::smo_state_t nextState;
	logic armed;
	logic inOrder;
	logic outOrder;
	logic dirOut;

	// a fresh start needs every sensor clear first
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			armed    <= 1'b0;
			inOrder  <= 1'b0;
			outOrder <= 1'b0;
		end else begin
			if (allOff) begin
				armed <= 1'b1;
			end else if (state == smo_pkg::SMO_IDLE &&
				nextState != smo_pkg::SMO_IDLE) begin
				armed <= 1'b0;
			end
			if (allOff) begin
				inOrder <= 1'b0;
			end else if (armed && muteSensor11 && !muteSensor12 &&
				!prev12) begin
				inOrder <= 1'b1;
			end
			if (allOff) begin
				outOrder <= 1'b0;
			end else if (armed && cfgMutingMode == smo_pkg::SMO_BIDIR &&
				muteSensor22 && !muteSensor21 && !prev21) begin
				outOrder <= 1'b1;
			end
		end
	end

	logic inStart;
	logic outStart;
	logic seqStart;
	logic seqSet;
	logic mutingStart;
	logic ovrStart;
	always_comb begin
		inStart  = muteSensor11 & muteSensor12 & inOrder;
		outStart = muteSensor22 & muteSensor21 & outOrder;
		unique case (cfgMutingMode)
			smo_pkg::SMO_POSITION: seqStart = muteSensor11;
			smo_pkg::SMO_PARALLEL: seqStart = inStart;
			smo_pkg::SMO_FORWARD:  seqStart = inStart;
			smo_pkg::SMO_BIDIR:    seqStart = inStart | outStart;
		endcase
		seqStart = seqStart & armed & curtainOn;
		mutingStart = seqStart & outputEnable & !faultPresent &
			!syncError & !curtainDiscError & !overrideDiscError;
		ovrStart = anyOn & !curtainAct & overrideOn;
		seqSet = 1'b0;
		if (state == smo_pkg::SMO_IDLE && armed) begin
			if (cfgMutingMode == smo_pkg::SMO_POSITION) begin
				seqSet = curtainFall & !muteSensor11;
			end else begin
				seqSet = (rise12 & !prev11 & !outOrder) |
					(curtainFall & anyOn);
			end
			if (cfgMutingMode == smo_pkg::SMO_FORWARD) begin
				seqSet = seqSet | ((rise21 | rise22) & !(prev11 & prev12));
			end
			if (cfgMutingMode == smo_pkg::SMO_BIDIR) begin
				seqSet = seqSet | (rise21 & !prev22 & !inOrder);
			end
		end
		seqSet = seqSet | (runEntry & !curtainOn);
	end

	// ****************************************
	// muting and override state
	// ****************************************
	logic [smo_pkg::SUB_W-1:0]  subCnt;
	logic [smo_pkg::LONG_W-1:0] halfCnt;
	logic endCond;
	logic muteExpired;
	logic ovrExpired;

	always_comb begin
		unique case (cfgMutingMode)
			smo_pkg::SMO_POSITION: endCond = !muteSensor11;
			smo_pkg::SMO_PARALLEL:
				endCond = !muteSensor11 | !muteSensor12;
			smo_pkg::SMO_FORWARD:
				endCond = !muteSensor11 & !muteSensor12 &
					!muteSensor21;
			smo_pkg::SMO_BIDIR:
				endCond = dirOut ?
					(!muteSensor12 & !muteSensor21 & !muteSensor22) :
					(!muteSensor11 & !muteSensor12 &
					!muteSensor21);
		endcase
		muteExpired = (cfgMaxMutingTime != '0) &&
			(halfCnt >= cfgMaxMutingTime);
		ovrExpired = halfCnt >= cfgMaxOverrideTime;
		nextState = state;
		unique case (state)
			smo_pkg::SMO_IDLE: begin
				if (mutingStart) begin
					nextState = smo_pkg::SMO_MUTE;
				end else if (ovrStart) begin
					nextState = smo_pkg::SMO_OVR;
				end
			end
			smo_pkg::SMO_MUTE: begin
				if (endCond || muteExpired || curtainDiscError ||
					overrideDiscError) begin
					nextState = smo_pkg::SMO_IDLE;
				end
			end
			smo_pkg::SMO_OVR: begin
				if (allOff || ovrExpired || !overrideOn) begin
					nextState = smo_pkg::SMO_IDLE;
				end
			end
			default: nextState = smo_pkg::SMO_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state  <= smo_pkg::SMO_IDLE;
			dirOut <= 1'b0;
		end else begin
			state <= nextState;
			if (state == smo_pkg::SMO_IDLE && mutingStart) begin
				dirOut <= cfgMutingMode == smo_pkg::SMO_BIDIR && !inStart;
			end
		end
	end

	// run time in half seconds, restarted on every entry
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			subCnt  <= '0;
			halfCnt <= '0;
		end else if (state == smo_pkg::SMO_IDLE) begin
			subCnt  <= '0;
			halfCnt <= '0;
		end else if (tick) begin
			if (subCnt == smo_pkg::SUB_LAST) begin
				subCnt <= '0;
				if (halfCnt != '1) begin
					halfCnt <= halfCnt + 1'b1;
				end
			end else begin
				subCnt <= subCnt + 1'b1;
			end
		end
	end

	// ****************************************
	// error flags, set beats clear
	// ****************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			curtainDiscError  <= 1'b0;
			overrideDiscError <= 1'b0;
			syncError         <= 1'b0;
			sequenceError     <= 1'b0;
			faultPresent      <= 1'b0;
		end else begin
			curtainDiscError  <= discOver[0] |
				(curtainDiscError & !curtainIdle);
			overrideDiscError <= discOver[1] |
				(overrideDiscError & (mismatch[1] | ovrAct));
			syncError     <= syncOver[0] | syncOver[1] |
				(syncError & !allOff);
			sequenceError <= seqSet | (sequenceError & !seqStart);
			faultPresent  <= (runEntry & !curtainOn) |
				(state == smo_pkg::SMO_IDLE && !curtainOn &&
				(sequenceError | syncError)) |
				(faultPresent & !curtainOn);
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			outputEnable   <= 1'b0;
			mutingStatus   <= 1'b0;
			overrideStatus <= 1'b0;
		end else begin
			// curtain ignored while muted or overridden
			outputEnable   <= (nextState != smo_pkg::SMO_IDLE) |
				(curtainOn & !(sequenceError & !prevCurtain));
			mutingStatus   <= nextState != smo_pkg::SMO_IDLE;
			overrideStatus <= nextState == smo_pkg::SMO_OVR;
		end
	end
endmodule
`default_nettype wire

// ===== smo_field_model.sv
`timescale 1ns/10ps
`default_nettype none
module smo_field_model (
	// configuration
	input  wire smo_pkg::smo_curtain_t cfgCurtainType,
	input  wire smo_pkg::smo_ovr_t     cfgOverrideType,
	// scene
	input  wire logic                  lcClear,
	input  wire logic                  lcFault,
	input  wire logic                  ovrPress,
	input  wire logic [3:0]            workpiece,
	// field pins
	output logic                       curtainCh1,
	output logic                       curtainCh2,
	output logic                       overrideCh1,
	output logic                       overrideCh2,
	output logic                       muteSensor11,
	output logic                       muteSensor12,
	output logic                       muteSensor21,
	output logic                       muteSensor22
);
	// ********
	// curtain pair, lcFault breaks channel 2
	// ********
	wire logic compl = cfgCurtainType == smo_pkg::SMO_LC_COMPL;
	assign curtainCh1 = lcClear;
	assign curtainCh2 = lcFault ^ (compl ? !lcClear : lcClear);
	// ********
	// override switch, channel 1 silent when unused
	// ********
	wire logic eq = cfgOverrideType == smo_pkg::SMO_OV_EQUIV;
	wire logic cp = cfgOverrideType == smo_pkg::SMO_OV_COMPL;
	assign overrideCh1 = ovrPress && !(cfgOverrideType == 2'h0);
	// lcFault breaks the second override channel as well
	assign overrideCh2 = lcFault ^ (eq ? ovrPress : (cp && !ovrPress));
	// ********
	// sensors on while a workpiece is seen
	// ********
	assign muteSensor11 = workpiece[0];
	assign muteSensor12 = workpiece[1];
	assign muteSensor21 = workpiece[2];
	assign muteSensor22 = workpiece[3];
endmodule
`default_nettype wire

// ===== smo_muting_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module smo_muting_checker #(
	parameter int unsigned TICK_CYCLES = smo_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input wire logic                       core_clk,
	input wire logic                       arst_n,
	// configuration
	input wire smo_pkg::smo_curtain_t      cfgCurtainType,
	input wire smo_pkg::smo_ovr_t          cfgOverrideType,
	input wire smo_pkg::smo_mode_t         cfgMutingMode,
	input wire logic [smo_pkg::LONG_W-1:0] cfgMaxOverrideTime,
	input wire logic [smo_pkg::LONG_W-1:0] cfgMaxMutingTime,
	// field
	input wire logic                       curtainCh1,
	input wire logic                       curtainCh2,
	input wire logic                       overrideCh1,
	input wire logic                       muteSensor11,
	input wire logic                       muteSensor12,
	input wire logic                       muteSensor21,
	input wire logic                       muteSensor22,
	// status
	input wire logic                       outputEnable,
	input wire logic                       mutingStatus,
	input wire logic                       overrideStatus,
	input wire logic                       curtainDiscError,
	input wire logic                       overrideDiscError
);
	// ********
	// run length; one tick of slack, the tick phase runs free
	// ********
	// wide counts: a full second-scale limit overflows a 32-bit int
	localparam longint HALF = smo_pkg::STEPS_PER_HALF;
	localparam longint TK   = TICK_CYCLES;
	longint runCnt;
	longint runLim;
	logic anyOn;
	assign anyOn = muteSensor11 || muteSensor12 || muteSensor21 || muteSensor22;
	always_comb begin
		if (overrideStatus)
			runLim = (longint'(cfgMaxOverrideTime) * HALF + 1) * TK + 2;
		else
			runLim = (longint'(cfgMaxMutingTime) * HALF + 1) * TK + 2;
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			runCnt <= 0;
		else
			runCnt <= mutingStatus ? runCnt + 1 : 0;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// ********
	// properties
	// ********
	a_ovr_needs_mute: assert property (overrideStatus |-> mutingStatus)
		else $error("override without muting status");
	a_mute_keeps_oe: assert property (mutingStatus |-> outputEnable)
		else $error("output enable low while muted");
	a_parallel_end: assert property (cfgMutingMode == smo_pkg::SMO_PARALLEL
		&& mutingStatus && !overrideStatus && !(muteSensor11 && muteSensor12)
		|=> !mutingStatus) else $error("parallel muting did not end");
	a_position_end: assert property (cfgMutingMode == smo_pkg::SMO_POSITION
		&& mutingStatus && !overrideStatus && !muteSensor11
		|=> !mutingStatus) else $error("position muting did not end");
	a_idle_curtain: assert property (!mutingStatus && !overrideCh1
		&& cfgCurtainType == smo_pkg::SMO_LC_EQUIV && !(curtainCh1 && curtainCh2)
		|=> !outputEnable) else $error("output enable without clear curtain");
	a_ovr_start: assert property (!mutingStatus && !$past(overrideStatus)
		&& cfgOverrideType == smo_pkg::SMO_OV_SINGLE && overrideCh1 && anyOn
		&& !curtainCh1 && !curtainCh2 && !curtainDiscError && !overrideDiscError
		|=> overrideStatus && outputEnable) else $error("override not started");
	a_ovr_release: assert property (overrideStatus && !overrideCh1
		|=> !overrideStatus && !mutingStatus) else $error("override kept on");
	a_ovr_all_off: assert property (overrideStatus && !anyOn
		|=> !overrideStatus) else $error("override kept with sensors off");
	a_run_limit: assert property (mutingStatus
		&& (overrideStatus || cfgMaxMutingTime != 8'h00) |-> runCnt < runLim)
		else $error("muting ran past its maximum time");
	a_disc_stops: assert property ($rose(curtainDiscError)
		|-> ##[0:1] !mutingStatus) else $error("muting kept after discrepancy");
	c_mute: cover property ($rose(mutingStatus) && !overrideStatus);
	c_ovr: cover property ($rose(overrideStatus));
	c_disc: cover property ($rose(curtainDiscError));
endmodule
bind smo_muting smo_muting_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);
`default_nettype wire

// ===== tb_safety_muting_override_block.sv
`timescale 1ns/10ps
`default_nettype none
module tb_safety_muting_override_block;
	logic                       core_clk;
	logic                       arst_n;
	smo_pkg::smo_curtain_t      cfgCurtainType;
	smo_pkg::smo_ovr_t          cfgOverrideType;
	smo_pkg::smo_mode_t         cfgMutingMode;
	logic [smo_pkg::DISC_W-1:0] cfgDisc;
	logic [smo_pkg::LONG_W-1:0] cfgMaxOvr;
	logic [smo_pkg::LONG_W-1:0] cfgMaxMute;
	logic [smo_pkg::SYNC_W-1:0] cfgSync;
	logic       runMode, lcClear, lcFault, ovrPress;
	logic [3:0] workpiece;
	wire logic  curtainCh1, curtainCh2, overrideCh1, overrideCh2;
	wire logic  muteSensor11, muteSensor12, muteSensor21, muteSensor22;
	logic       outputEnable, mutingStatus, overrideStatus, faultPresent;
	logic       syncError, sequenceError, curtainDiscError, overrideDiscError;
	int         err_total, compares, n;
	// short tick keeps the run small; setpoints still exceed a cycle
	smo_muting #(.TICK_CYCLES(10)) dut (.core_clk, .arst_n, .cfgCurtainType,
		.cfgOverrideType, .cfgMutingMode, .cfgCurtainDiscTime(cfgDisc),
		.cfgOverrideDiscTime(cfgDisc), .cfgMaxOverrideTime(cfgMaxOvr),
		.cfgMaxMutingTime(cfgMaxMute), .cfgSyncTime(cfgSync), .runMode,
		.curtainCh1, .curtainCh2, .overrideCh1, .overrideCh2, .muteSensor11,
		.muteSensor12, .muteSensor21, .muteSensor22, .outputEnable,
		.mutingStatus, .overrideStatus, .faultPresent, .syncError,
		.sequenceError, .curtainDiscError, .overrideDiscError);
	smo_field_model u_field (.cfgCurtainType, .cfgOverrideType, .lcClear,
		.lcFault, .ovrPress, .workpiece, .curtainCh1, .curtainCh2,
		.overrideCh1, .overrideCh2, .muteSensor11, .muteSensor12,
		.muteSensor21, .muteSensor22);
	always #5 core_clk = ~core_clk;
	// ********
	// tasks
	// ********
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("compares=%0d mismatches=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_drop(input int lim, output int cnt);
		cnt = 0;
		while (mutingStatus !== 1'b0 && cnt < lim) begin
			tick(1);
			cnt++;
		end
		if (cnt >= lim) begin
			chk(8'h01, 8'h00);
			final_report();
		end
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		tick(16);
		arst_n = 1'b1;
		tick(2);
	endtask
	// sensor 11 first, then 12
	task automatic walk();
		workpiece = 4'h1;
		tick(1);
		workpiece = 4'h3;
		tick(1);
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		cfgCurtainType = smo_pkg::SMO_LC_EQUIV;
		cfgOverrideType = smo_pkg::SMO_OV_SINGLE;
		cfgMutingMode = smo_pkg::SMO_PARALLEL;
		cfgDisc = 6'h03;
		cfgMaxOvr = 8'h01;
		cfgMaxMute = 8'h02;
		cfgSync = 9'h003;
		{runMode, lcClear, lcFault, ovrPress} = 4'h8;
		workpiece = 4'h0;
		err_total = 0;
		compares = 0;
		do_reset();
		tick(2);
		chk({faultPresent, sequenceError}, 8'h03);
		lcClear = 1'b1;
		tick(3);
		chk(faultPresent, 8'h00);
		walk();
		chk({outputEnable, mutingStatus, overrideStatus}, 8'h06);
		tick(2);
		chk(sequenceError, 8'h00);
		lcClear = 1'b0;
		tick(3);
		chk(outputEnable, 8'h01);
		workpiece = 4'h1;
		tick(2);
		chk({outputEnable, mutingStatus, overrideStatus}, 8'h00);
		{workpiece, lcClear} = 5'h01;
		tick(5);
		chk(outputEnable, 8'h01);
		walk();
		wait_drop(1200, n);
		chk(n >= 980, 8'h01);
		tick(20);
		chk(mutingStatus, 8'h00);
		workpiece = 4'h0;
		tick(3);
		walk();
		chk(mutingStatus, 8'h01);
		lcFault = 1'b1;
		wait_drop(80, n);
		chk(n >= 20, 8'h01);
		chk(curtainDiscError, 8'h01);
		{workpiece, lcFault} = 5'h00;
		$display("muting sequence done");
		do_reset();
		workpiece = 4'h1;
		tick(50);
		workpiece = 4'h3;
		tick(2);
		chk({syncError, mutingStatus}, 8'h02);
		lcClear = 1'b0;
		tick(3);
		chk({outputEnable, faultPresent}, 8'h01);
		{workpiece, lcClear} = 5'h01;
		$display("synchronization done");
		do_reset();
		{workpiece, lcClear, ovrPress} = 6'h05;
		tick(1);
		chk({outputEnable, mutingStatus, overrideStatus}, 8'h07);
		ovrPress = 1'b0;
		tick(1);
		chk({mutingStatus, overrideStatus}, 8'h00);
		tick(1);
		chk(outputEnable, 8'h00);
		ovrPress = 1'b1;
		tick(1);
		chk({outputEnable, mutingStatus, overrideStatus}, 8'h07);
		wait_drop(540, n);
		ovrPress = 1'b0;
		chk(n >= 480, 8'h01);
		tick(3);
		ovrPress = 1'b1;
		tick(1);
		chk(overrideStatus, 8'h01);
		workpiece = 4'h0;
		tick(1);
		chk(overrideStatus, 8'h00);
		{lcClear, ovrPress} = 2'h2;
		$display("override done");
		cfgMutingMode = smo_pkg::SMO_FORWARD;
		do_reset();
		walk();
		chk(mutingStatus, 8'h01);
		workpiece = 4'h4;
		tick(2);
		chk(mutingStatus, 8'h01);
		workpiece = 4'h0;
		tick(1);
		chk(mutingStatus, 8'h00);
		cfgMutingMode = smo_pkg::SMO_BIDIR;
		tick(2);
		workpiece = 4'h8;
		tick(1);
		workpiece = 4'hC;
		tick(1);
		chk(mutingStatus, 8'h01);
		workpiece = 4'h1;
		tick(1);
		chk(mutingStatus, 8'h00);
		workpiece = 4'h0;
		$display("sequential modes done");
		cfgMutingMode = smo_pkg::SMO_POSITION;
		do_reset();
		workpiece = 4'h1;
		tick(2);
		chk(mutingStatus, 8'h01);
		lcClear = 1'b0;
		tick(2);
		chk(outputEnable, 8'h01);
		workpiece = 4'h0;
		tick(1);
		chk(mutingStatus, 8'h00);
		tick(1);
		chk(outputEnable, 8'h00);
		$display("position mode done");
		cfgCurtainType = smo_pkg::SMO_LC_COMPL;
		cfgOverrideType = smo_pkg::SMO_OV_EQUIV;
		lcClear = 1'b1;
		do_reset();
		lcFault = 1'b1;
		tick(40);
		chk({curtainDiscError, overrideDiscError}, 8'h03);
		lcFault = 1'b0;
		tick(2);
		chk(overrideDiscError, 8'h00);
		chk(curtainDiscError, 8'h01);
		$display("discrepancy done");
		final_report();
	end
endmodule
`default_nettype wire
